// File: hw/tsp_i2c_tgt.v
`include "tsp_defines.vh"

module tsp_i2c_tgt (
	input  wire       mclk,
	input  wire       rst,
	input  wire       scl_i,
	input  wire       sda_i,
	input  wire [7:0] tx_data,
	output reg        addr_stb_q,
	output reg        sel_spd_q,
	output reg        a8_q,
	output reg        rw_q,
	output reg        wr_stb_q,
	output reg  [7:0] wr_data_q,
	output reg        rd_adv_q,
	output reg        sda_oe_q
);
	localparam S_IDLE = 7'h01;
	localparam S_ADDR = 7'h02;
	localparam S_ACKA = 7'h04;
	localparam S_WR   = 7'h08;
	localparam S_ACKW = 7'h10;
	localparam S_RD   = 7'h20;
	localparam S_ACKR = 7'h40;

	reg [1:0] scl_s_q;
	reg [1:0] sda_s_q;
	reg       scl_p_q;
	reg       sda_p_q;
	reg [6:0] st_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg       nack_q;

	wire scl_rise = scl_s_q[1] & ~scl_p_q;
	wire scl_fall = ~scl_s_q[1] & scl_p_q;
	wire start    = scl_s_q[1] & scl_p_q & ~sda_s_q[1] & sda_p_q;
	wire stop     = scl_s_q[1] & scl_p_q & sda_s_q[1] & ~sda_p_q;
	wire m_sens   = (sh_q[7:1] == `TSP_SENS_ADDR);
	wire m_spd    = (sh_q[7:2] == `TSP_SPD_ADDR_HI);

	// ==========================================================
	// pin synchronisers
	always @(posedge mclk) begin
		if (rst) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_i};
			sda_s_q <= {sda_s_q[0], sda_i};
			scl_p_q <= scl_s_q[1];
			sda_p_q <= sda_s_q[1];
		end
	end

	// ==========================================================
	// target engine, every bit timed by the host's clock
	always @(posedge mclk) begin
		if (rst) begin
			st_q       <= S_IDLE;
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			nack_q     <= 1'b0;
			sda_oe_q   <= 1'b0;
			addr_stb_q <= 1'b0;
			sel_spd_q  <= 1'b0;
			a8_q       <= 1'b0;
			rw_q       <= 1'b0;
			wr_stb_q   <= 1'b0;
			wr_data_q  <= 8'h00;
			rd_adv_q   <= 1'b0;
		end else begin
			addr_stb_q <= 1'b0;
			wr_stb_q   <= 1'b0;
			rd_adv_q   <= 1'b0;
			if (start) begin
				st_q     <= S_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (stop) begin
				st_q     <= S_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (st_q)
				S_ADDR, S_WR: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s_q[1]};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (st_q == S_WR) begin
							wr_stb_q  <= 1'b1;
							wr_data_q <= sh_q;
							sda_oe_q  <= 1'b1;
							st_q      <= S_ACKW;
						end else if (m_sens || m_spd) begin
							addr_stb_q <= 1'b1;
							sel_spd_q  <= m_spd;
							a8_q       <= sh_q[1];
							rw_q       <= sh_q[0];
							sda_oe_q   <= 1'b1;
							st_q       <= S_ACKA;
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				S_ACKA, S_ACKW: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (st_q == S_ACKA && rw_q) begin
							sh_q     <= tx_data;
							sda_oe_q <= ~tx_data[7];
							st_q     <= S_RD;
						end else begin
							sda_oe_q <= 1'b0;
							st_q     <= S_WR;
						end
					end
				end
				S_RD: begin
					if (scl_fall) begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h7) begin
							sda_oe_q <= 1'b0;
							st_q     <= S_ACKR;
						end else begin
							sh_q     <= {sh_q[6:0], 1'b0};
							sda_oe_q <= ~sh_q[6];
						end
					end
				end
				S_ACKR: begin
					if (scl_rise) begin
						nack_q   <= sda_s_q[1];
						rd_adv_q <= 1'b1;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						if (nack_q) begin
							st_q <= S_IDLE;
						end else begin
							sh_q     <= tx_data;
							sda_oe_q <= ~tx_data[7];
							st_q     <= S_RD;
						end
					end
				end
				S_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				default: begin
					st_q     <= S_IDLE;
					sda_oe_q <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule

// File: hw/tsp_top.v
`include "tsp_defines.vh"

// Contract
// - sample board temperature continuously; refresh register each sample.
// - host reads current temperature any time, no conversion command needed.
// - offer writable limit registers and read-only temperature registers.
// - alert pin is active low open drain; only pulls low.
// - alert asserts only for conditions the host enabled in configuration.
// - the presence-detect store never touches the alert pin.
// - three alert behaviours: latched interrupt, comparator, critical-only.
// - interrupt alert holds until host writes one to clear-event bit.
// - comparator alert releases by itself once the condition goes away.
// - comparison against critical limit always behaves as comparator.
// - critical-only mode asserts alert only above the critical limit.
// - critical alert holds until below limit minus hysteresis.
// - store holds 512 bytes in four 128-byte blocks; the top block is never protected.
// - blocks 0, 1 and 3 hold configuration, module and user data.
// - bytes 100h-13Fh read 00h; 140h-17Fh hold manufacturing data.
// - lowest 384 bytes come preloaded with standard content.
// - store sits only on the two-wire link, no memory bus.
// - device is a target only; host makes the serial clock.
// - serial clock up to 1 MHz accepted; host keeps it there.
// - software sets and clears write protection over bytes 0 to 383; code keeps bytes 100h-13Fh unwritable even when it is cleared.
// - top 128 bytes are never protected and always writable.
module tsp_top (
	input  wire        mclk,
	input  wire        rst,
	input  wire        scl_i,
	input  wire        sda_i,
	input  wire [12:0] temp_meas,
	input  wire        temp_stb,
	output reg         sda_o,
	output wire        sda_oe,
	output reg         alert_n_o,
	output reg         alert_n_oe,
	output reg  [12:0] temp_o,
	output reg         spd_wp_o
);
	// ==========================================================
	// helpers
	function [7:0] spd_factory;
		input [8:0] a;
		begin
			if (a >= `TSP_USER_LO)
				spd_factory = `TSP_ERASED;
			else if (a >= `TSP_RSV_LO && a <= `TSP_RSV_HI)
				spd_factory = 8'h00;
			else
				spd_factory = a[7:0] ^ `TSP_FACTORY_SEED;
		end
	endfunction

	function spd_writable;
		input [8:0] a;
		input       wp;
		begin
			if (a >= `TSP_USER_LO)
				spd_writable = 1'b1;
			else if (a >= `TSP_RSV_LO && a <= `TSP_RSV_HI)
				spd_writable = 1'b0;
			else
				spd_writable = ~wp;
		end
	endfunction

	function [13:0] hyst_val;
		input [1:0] sel;
		begin
			case (sel)
			2'h0:    hyst_val = `TSP_HYST_0;
			2'h1:    hyst_val = `TSP_HYST_1;
			2'h2:    hyst_val = `TSP_HYST_2;
			default: hyst_val = `TSP_HYST_3;
			endcase
		end
	endfunction

	// ==========================================================
	// state
	reg  [7:0]  mem_q [0:`TSP_SPD_BYTES-1];
	reg  [8:0]  spd_ptr_q;
	reg  [3:0]  ptr_q;
	reg  [1:0]  widx_q;
	reg  [7:0]  wmsb_q;
	reg         rd_lsb_q;
	reg  [15:0] cfg_q;
	reg  [15:0] upper_q;
	reg  [15:0] lower_q;
	reg  [15:0] crit_q;
	reg  [12:0] temp_q;
	reg         crit_hold_q;
	reg         win_prev_q;
	reg         int_q;
	reg         evt_q;
	reg         wp_q;
	reg         evt_d;
	reg  [15:0] sword;
	reg  [7:0]  tx_data;
	integer     i;

	wire        addr_stb;
	wire        sel_spd;
	wire        a8;
	wire        rw;
	wire        wr_stb;
	wire [7:0]  wr_data;
	wire        rd_adv;

	// ==========================================================
	// serial target; the store has no other port
	tsp_i2c_tgt u_tgt (
		.mclk       (mclk),
		.rst        (rst),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.tx_data    (tx_data),
		.addr_stb_q (addr_stb),
		.sel_spd_q  (sel_spd),
		.a8_q       (a8),
		.rw_q       (rw),
		.wr_stb_q   (wr_stb),
		.wr_data_q  (wr_data),
		.rd_adv_q   (rd_adv),
		.sda_oe_q   (sda_oe)
	);

	// ==========================================================
	// limit comparisons
	wire signed [13:0] t_s    = {temp_q[12], temp_q};
	wire signed [13:0] up_s   = {upper_q[12], upper_q[12:0]};
	wire signed [13:0] lo_s   = {lower_q[12], lower_q[12:0]};
	wire signed [13:0] cr_s   = {crit_q[12], crit_q[12:0]};
	wire        [13:0] hy     =
		hyst_val(cfg_q[`TSP_CFG_HYST_HI:`TSP_CFG_HYST_LO]);
	wire signed [13:0] cr_rel = cr_s - $signed(hy);
	wire above_up  = t_s > up_s;
	wire below_lo  = t_s < lo_s;
	wire above_cr  = t_s > cr_s;
	wire under_rel = t_s < cr_rel;
	wire window    = above_up | below_lo;
	wire int_mode  = cfg_q[`TSP_CFG_INTMODE];
	wire crit_only = cfg_q[`TSP_CFG_CRITONLY];
	wire evt_en    = cfg_q[`TSP_CFG_EN];

	// sensor write lands on the low byte of a word
	wire s_commit  = wr_stb & ~sel_spd & (widx_q == 2'h2);
	wire clr_evt   = s_commit & (ptr_q == `TSP_PTR_STAT) &
	                 wr_data[`TSP_STAT_CLR];

	// ==========================================================
	// alert decision
	always @* begin
		if (!evt_en)
			evt_d = 1'b0;
		else if (crit_only)
			evt_d = crit_hold_q;
		else if (int_mode)
			evt_d = crit_hold_q | int_q;
		else
			evt_d = crit_hold_q | window;
	end

	// ==========================================================
	// read data; temperature is always the latest sample
	always @* begin
		case (ptr_q)
		`TSP_PTR_CAPS:  sword = `TSP_CAPS_VAL;
		`TSP_PTR_CFG:   sword = cfg_q;
		`TSP_PTR_UPPER: sword = upper_q;
		`TSP_PTR_LOWER: sword = lower_q;
		`TSP_PTR_CRIT:  sword = crit_q;
		`TSP_PTR_TEMP:  sword = {above_cr, above_up, below_lo, temp_q};
		`TSP_PTR_STAT:  sword = {15'h0000, evt_q};
		`TSP_PTR_WP:    sword = {15'h0000, wp_q};
		default:        sword = 16'h0000;
		endcase
		if (sel_spd)
			tx_data = mem_q[spd_ptr_q];
		else if (rd_lsb_q)
			tx_data = sword[7:0];
		else
			tx_data = sword[15:8];
	end

	// ==========================================================
	// sensor side
	always @(posedge mclk) begin
		if (rst) begin
			temp_q      <= `TSP_TEMP_RST;
			cfg_q       <= `TSP_CFG_RST;
			upper_q     <= `TSP_UPPER_RST;
			lower_q     <= `TSP_LOWER_RST;
			crit_q      <= `TSP_CRIT_RST;
			crit_hold_q <= 1'b0;
			win_prev_q  <= 1'b0;
			int_q       <= 1'b0;
			evt_q       <= 1'b0;
			wp_q        <= 1'b0;
		end else begin
			if (temp_stb)
				temp_q <= temp_meas;
			if (above_cr)
				crit_hold_q <= 1'b1;
			else if (under_rel)
				crit_hold_q <= 1'b0;
			win_prev_q <= window;
			// a fresh crossing beats a clear in the same cycle
			if (int_mode && window && !win_prev_q)
				int_q <= 1'b1;
			else if (clr_evt || !int_mode)
				int_q <= 1'b0;
			evt_q <= evt_d;
			if (s_commit) begin
				case (ptr_q)
				`TSP_PTR_CFG:   cfg_q   <= {wmsb_q, wr_data};
				`TSP_PTR_UPPER: upper_q <= {wmsb_q, wr_data};
				`TSP_PTR_LOWER: lower_q <= {wmsb_q, wr_data};
				`TSP_PTR_CRIT:  crit_q  <= {wmsb_q, wr_data};
				`TSP_PTR_WP:    wp_q    <= wr_data[`TSP_WP_BIT];
				default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// pointers and byte sequencing
	always @(posedge mclk) begin
		if (rst) begin
			ptr_q     <= `TSP_PTR_CAPS;
			spd_ptr_q <= 9'h000;
			widx_q    <= 2'h0;
			wmsb_q    <= 8'h00;
			rd_lsb_q  <= 1'b0;
		end else if (addr_stb) begin
			widx_q   <= 2'h0;
			rd_lsb_q <= 1'b0;
			if (sel_spd)
				spd_ptr_q[8] <= a8;
		end else if (wr_stb) begin
			if (widx_q == 2'h0) begin
				if (sel_spd)
					spd_ptr_q <= {a8, wr_data};
				else
					ptr_q <= wr_data[3:0];
				widx_q <= 2'h1;
			end else if (sel_spd) begin
				spd_ptr_q <= spd_ptr_q + 9'h001;
			end else if (widx_q == 2'h1) begin
				wmsb_q <= wr_data;
				widx_q <= 2'h2;
			end else begin
				widx_q <= 2'h1;
			end
		end else if (rd_adv && rw) begin
			if (sel_spd)
				spd_ptr_q <= spd_ptr_q + 9'h001;
			else
				rd_lsb_q <= ~rd_lsb_q;
		end
	end

	// ==========================================================
	// store array; reset stands in for factory programming
	always @(posedge mclk) begin
		if (rst) begin
			for (i = 0; i < `TSP_SPD_BYTES; i = i + 1)
				mem_q[i] <= spd_factory(i[8:0]);
		end else if (wr_stb && sel_spd && widx_q != 2'h0 &&
		             spd_writable(spd_ptr_q, wp_q)) begin
			mem_q[spd_ptr_q] <= wr_data;
		end
	end

	// ==========================================================
	// pins; open drain means the data level is always low
	always @(posedge mclk) begin
		if (rst) begin
			sda_o      <= 1'b0;
			alert_n_o  <= 1'b0;
			alert_n_oe <= 1'b0;
			temp_o     <= `TSP_TEMP_RST;
			spd_wp_o   <= 1'b0;
		end else begin
			sda_o      <= 1'b0;
			alert_n_o  <= 1'b0;
			alert_n_oe <= evt_d;
			temp_o     <= temp_q;
			spd_wp_o   <= wp_q;
		end
	end
endmodule

// File: shared/tsp_defines.vh
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH

// ==========================================================
// link addresses
`define TSP_SENS_ADDR     7'h18
`define TSP_SPD_ADDR_HI   6'h28
// ==========================================================
// sensor word pointers
`define TSP_PTR_CAPS      4'h0
`define TSP_PTR_CFG       4'h1
`define TSP_PTR_UPPER     4'h2
`define TSP_PTR_LOWER     4'h3
`define TSP_PTR_CRIT      4'h4
`define TSP_PTR_TEMP      4'h5
`define TSP_PTR_STAT      4'h6
`define TSP_PTR_WP        4'h7
// ==========================================================
// config fields
`define TSP_CFG_INTMODE   0
`define TSP_CFG_CRITONLY  2
`define TSP_CFG_EN        3
`define TSP_CFG_HYST_LO   9
`define TSP_CFG_HYST_HI   10
// ==========================================================
// status and protect fields
`define TSP_STAT_EVT      0
`define TSP_STAT_CLR      5
`define TSP_WP_BIT        0
// ==========================================================
// reset values
`define TSP_CAPS_VAL      16'h0001
`define TSP_CFG_RST       16'h0000
`define TSP_UPPER_RST     16'h0000
`define TSP_LOWER_RST     16'h0000
`define TSP_CRIT_RST      16'h0000
`define TSP_TEMP_RST      13'h0000
`define TSP_ERASED        8'hff
`define TSP_FACTORY_SEED  8'h5a
// ==========================================================
// critical hysteresis in sixteenths of a degree
`define TSP_HYST_0        14'h0000
`define TSP_HYST_1        14'h0018
`define TSP_HYST_2        14'h0030
`define TSP_HYST_3        14'h0060
// ==========================================================
// store layout
`define TSP_SPD_BYTES     512
`define TSP_RSV_LO        9'h100
`define TSP_RSV_HI        9'h13f
`define TSP_USER_LO       9'h180

`endif

// File: verification/testbench.sv
`include "tsp_defines.vh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// signals
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [12:0] temp_meas = 13'h0000;
	logic        temp_stb = 1'b0;
	wire         scl;
	wire         host_pull;
	wire         sda_oe;
	wire         alert_n_oe;
	wire  [12:0] temp_o;
	wire         spd_wp_o;
	wire         sda = ~(sda_oe | host_pull);
	int          err_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic        ack;
	logic [15:0] w;
	logic [7:0]  b;
	logic [7:0]  e;
	logic [8:0]  tab [9] = '{9'h000, 9'h07f, 9'h0ff, 9'h100, 9'h13f,
		9'h140, 9'h17f, 9'h180, 9'h1ff};

	always #50 mclk = ~mclk;

	tsp_top u_tsp_top (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda),
		.temp_meas(temp_meas), .temp_stb(temp_stb), .sda_o(),
		.sda_oe(sda_oe), .alert_n_o(), .alert_n_oe(alert_n_oe),
		.temp_o(temp_o), .spd_wp_o(spd_wp_o));
	tsp_host u_tsp_host (.scl(scl), .sda_pull(host_pull), .sda(sda));

	// ==========================================
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// a hang in the serial handshake ends here
	always @(posedge mclk)
		if (++cyc == 40000) begin
			err_count++;
			conclude();
		end

	task automatic swr(input logic [3:0] p, input logic [15:0] d);
		u_tsp_host.start();
		u_tsp_host.put({`TSP_SENS_ADDR, 1'b0}, ack);
		u_tsp_host.put({4'h0, p}, ack);
		u_tsp_host.put(d[15:8], ack);
		u_tsp_host.put(d[7:0], ack);
		u_tsp_host.stop();
	endtask

	task automatic srd(input logic [3:0] p, output logic [15:0] d);
		u_tsp_host.start();
		u_tsp_host.put({`TSP_SENS_ADDR, 1'b0}, ack);
		u_tsp_host.put({4'h0, p}, ack);
		u_tsp_host.start();
		u_tsp_host.put({`TSP_SENS_ADDR, 1'b1}, ack);
		u_tsp_host.get(1'b0, d[15:8]);
		u_tsp_host.get(1'b1, d[7:0]);
		u_tsp_host.stop();
	endtask

	task automatic ewr(input logic [8:0] a, input logic [7:0] d);
		u_tsp_host.start();
		u_tsp_host.put({`TSP_SPD_ADDR_HI, a[8], 1'b0}, ack);
		u_tsp_host.put(a[7:0], ack);
		u_tsp_host.put(d, ack);
		u_tsp_host.stop();
	endtask

	task automatic erd(input logic [8:0] a, output logic [7:0] d);
		u_tsp_host.start();
		u_tsp_host.put({`TSP_SPD_ADDR_HI, a[8], 1'b0}, ack);
		u_tsp_host.put(a[7:0], ack);
		u_tsp_host.start();
		u_tsp_host.put({`TSP_SPD_ADDR_HI, a[8], 1'b1}, ack);
		u_tsp_host.get(1'b1, d);
		u_tsp_host.stop();
	endtask

	task automatic step(input logic [12:0] t);
		@(posedge mclk) #5 temp_meas = t;
		temp_stb = 1'b1;
		@(posedge mclk) #5 temp_stb = 1'b0;
		repeat (4) @(posedge mclk);
		#5;
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset;
		check({sda_oe, alert_n_oe, spd_wp_o}, 3'b000);
		check(temp_o, 13'h0000);
	endtask

	task automatic t_temp;
		step(13'h0190);
		check(temp_o, 13'h0190);
		check(alert_n_oe, 1'b0);
		srd(`TSP_PTR_TEMP, w);
		check(w, 16'hc190);
		swr(`TSP_PTR_CAPS, 16'hffff);
		srd(`TSP_PTR_CAPS, w);
		check(w, `TSP_CAPS_VAL);
		swr(`TSP_PTR_UPPER, 16'h0320);
		srd(`TSP_PTR_UPPER, w);
		check(w, 16'h0320);
	endtask

	task automatic t_alert;
		swr(`TSP_PTR_CRIT, 16'h0300);
		swr(`TSP_PTR_CFG, 16'h0009);
		step(13'h0310);
		check(alert_n_oe, 1'b1);
		step(13'h0190);
		check(alert_n_oe, 1'b0);
		step(13'h0400);
		step(13'h0190);
		check(alert_n_oe, 1'b1);
		srd(`TSP_PTR_STAT, w);
		check(w, 16'h0001);
		swr(`TSP_PTR_STAT, 16'h0020);
		check(alert_n_oe, 1'b0);
		swr(`TSP_PTR_CFG, 16'h0008);
		step(13'h1f00);
		check(alert_n_oe, 1'b1);
		step(13'h0190);
		check(alert_n_oe, 1'b0);
		swr(`TSP_PTR_CRIT, 16'h0500);
		swr(`TSP_PTR_CFG, 16'h020c);
		step(13'h0400);
		check(alert_n_oe, 1'b0);
		step(13'h0510);
		check(alert_n_oe, 1'b1);
		step(13'h04f0);
		check(alert_n_oe, 1'b1);
		step(13'h04e0);
		check(alert_n_oe, 1'b0);
		swr(`TSP_PTR_CFG, 16'h0000);
		step(13'h0510);
		check(alert_n_oe, 1'b0);
	endtask

	task automatic t_store;
		for (int i = 0; i < 9; i++) begin
			if (tab[i] >= `TSP_USER_LO)
				e = `TSP_ERASED;
			else if (tab[i] >= `TSP_RSV_LO && tab[i] <= `TSP_RSV_HI)
				e = 8'h00;
			else
				e = tab[i][7:0] ^ `TSP_FACTORY_SEED;
			erd(tab[i], b);
			check(b, e);
		end
		swr(`TSP_PTR_WP, 16'h0001);
		check(spd_wp_o, 1'b1);
		ewr(9'h17f, 8'h33);
		check(ack, 1'b1);
		erd(9'h17f, b);
		check(b, 8'h7f ^ `TSP_FACTORY_SEED);
		ewr(9'h180, 8'h33);
		erd(9'h180, b);
		check(b, 8'h33);
		swr(`TSP_PTR_WP, 16'h0000);
		check(spd_wp_o, 1'b0);
		ewr(9'h17f, 8'h33);
		erd(9'h17f, b);
		check(b, 8'h33);
		ewr(9'h120, 8'h77);
		erd(9'h120, b);
		check(b, 8'h00);
		u_tsp_host.start();
		u_tsp_host.put(8'h54, ack);
		u_tsp_host.stop();
		check(ack, 1'b0);
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		#5 rst = 1'b0;
		repeat (4) @(posedge mclk);
		#5;
		t_reset();
		t_temp();
		t_alert();
		t_store();
		conclude();
	end
endmodule

bind tsp_top tsp_top_sva u_tsp_top_sva (.mclk(mclk), .rst(rst),
	.scl_i(scl_i), .sda_i(sda_i), .temp_meas(temp_meas),
	.temp_stb(temp_stb), .sda_o(sda_o), .sda_oe(sda_oe),
	.alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
	.temp_o(temp_o), .spd_wp_o(spd_wp_o));

// File: verification/tsp_host.sv
module tsp_host (
	output logic scl,
	output logic sda_pull,
	input  wire  sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// link controller, 1300 ns bit time
	// low phase kept long so the target answers well before scl rises
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic bit_x(input logic b, output logic r);
		#350 sda_pull = ~b;
		#350 scl = 1'b1;
		#590 r = sda;
		#10 scl = 1'b0;
	endtask

	task automatic start;
		#350 sda_pull = 1'b0;
		#350 scl = 1'b1;
		#350 sda_pull = 1'b1;
		#600 scl = 1'b0;
	endtask

	task automatic stop;
		#350 sda_pull = 1'b1;
		#350 scl = 1'b1;
		#600 sda_pull = 1'b0;
		#600;
	endtask

	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask

	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_x(1'b1, r);
			d = {d[6:0], r};
		end
		bit_x(last, r);
	endtask
endmodule

// File: verification/tsp_top_sva.sv
module tsp_top_sva (
	input wire        mclk,
	input wire        rst,
	input wire        scl_i,
	input wire        sda_i,
	input wire [12:0] temp_meas,
	input wire        temp_stb,
	input wire        sda_o,
	input wire        sda_oe,
	input wire        alert_n_o,
	input wire        alert_n_oe,
	input wire [12:0] temp_o,
	input wire        spd_wp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// port rules
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_sda_low_only: assert property (sda_o == 1'b0)
		else $error("sda value not low");
	a_alert_low_only: assert property (alert_n_o == 1'b0)
		else $error("alert value not low");
	a_temp_load: assert property (
		temp_stb |-> ##2 temp_o == $past(temp_meas, 2))
		else $error("temperature not loaded");
	a_temp_hold: assert property (
		!$past(temp_stb) && !$past(temp_stb, 2) |-> $stable(temp_o))
		else $error("temperature moved without sample");
	// no disable here: reset itself is the cause
	a_quiet_reset: assert property (disable iff (1'b0)
		rst |=> !sda_oe && !alert_n_oe && !spd_wp_o && temp_o == 13'h0000)
		else $error("outputs not quiet after reset");
	a_sda_scl_low: assert property (
		$changed(sda_oe) |-> !scl_i)
		else $error("sda moved while scl high");
	a_sda_drive_hold: assert property (
		$rose(sda_oe) |=> sda_oe [*8])
		else $error("driven bit too short");
	a_sda_free_hold: assert property (
		$fell(sda_oe) |=> !sda_oe [*8])
		else $error("released bit too short");
endmodule
